// file: common/rcc_pkg.sv
// shared constants and carriers of the receive clock correction block
`default_nettype none
package rcc_pkg;
	localparam int DATA_W = 8;
	localparam int ELEMS  = 4;
	localparam int ADDR_W = 12;
	localparam int LAT_W  = 6;
	localparam int SPC_W  = 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CTRL  = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_LAT   = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_SPACE = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_SEQ1  = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_SEQ2  = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_MASK  = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_STAT  = 12'h018;

	// field positions
	localparam int CTRL_ENA_BIT  = 0;
	localparam int CTRL_PRIO_BIT = 1;
	localparam int CTRL_SEL2_BIT = 2;
	localparam int CTRL_KEEP_BIT = 3;
	localparam int CTRL_ADJ_LSB  = 4;
	localparam int CTRL_DET_LSB  = 8;
	localparam int LEN_W         = 3;
	localparam int LAT_FLOOR_LSB = 0;
	localparam int LAT_CEIL_LSB  = 8;
	localparam int MASK1_LSB     = 0;
	localparam int MASK2_LSB     = 4;
	localparam int STAT_OCC_LSB  = 0;
	localparam int STAT_SEQ_LSB  = 8;
	localparam int STAT_OVF_BIT  = 16;
	localparam int STAT_BOND_BIT = 17;

	// writable bits and reset values
	localparam logic [31:0] CTRL_WMASK  = 32'h0000_077f;
	localparam logic [31:0] LAT_WMASK   = 32'h0000_3f3f;
	localparam logic [31:0] SPACE_WMASK = 32'h0000_00ff;
	localparam logic [31:0] MASK_WMASK  = 32'h0000_00ff;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0111;
	localparam logic [31:0] LAT_RST     = 32'h0000_1808;
	localparam logic [31:0] SPACE_RST   = 32'h0000_0000;
	localparam logic [31:0] SEQ_RST     = 32'h0000_0000;
	localparam logic [31:0] MASK_RST    = 32'h0000_00ff;

	// reader pace in clk cycles, a little faster than the link byte rate
	localparam int RD_PERIOD_DEF = 31;

	typedef struct packed {
		logic                    ena;
		logic                    prio;
		logic                    sel2;
		logic                    keep;
		logic [LEN_W-1:0]        adjLen;
		logic [LEN_W-1:0]        detLen;
		logic [LAT_W-1:0]        floorLat;
		logic [LAT_W-1:0]        ceilLat;
		logic [SPC_W-1:0]        spacing;
		logic [ELEMS*DATA_W-1:0] seq1;
		logic [ELEMS*DATA_W-1:0] seq2;
		logic [ELEMS-1:0]        mask1;
		logic [ELEMS-1:0]        mask2;
	} rcc_cfg_s;

	typedef struct packed {
		logic              valid;
		logic [DATA_W-1:0] data;
	} rcc_byte_s;
endpackage
`default_nettype wire

// file: rtl/rcc_ebuf_mem.sv
// elastic buffer storage with registered read data
`timescale 1ns/1ns
`default_nettype none
module rcc_ebuf_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic                     clk,
	input  wire logic                     wrEn,
	input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
	input  wire logic [WIDTH-1:0]         wrData,
	input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
	output logic      [WIDTH-1:0]         rdData
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rdData_ff;

	always_ff @(posedge clk)
	begin
		if (wrEn)
		begin
			mem[wrAddr] <= wrData;
		end
		rdData_ff <= mem[rdAddr];
	end

	assign rdData = rdData_ff;
endmodule
`default_nettype wire

// file: rtl/rcc_rx_clock_correction.sv
// receive clock correction: pattern match, elastic buffer, repeat and skip
// Summary of operation
// - no byte is repeated or skipped unless the correction enable bit is set.
// - on a tie between correction and bonding the priority bit picks which goes first.
// - after a correction at least the spacing count of clk cycles pass before the next.
// - occupancy below the latency floor calls for a repeat.
// - the first pattern is four element bytes compared under the first mask.
// - an element whose first-mask bit is clear matches any byte.
// - the second pattern is four more element bytes used with the second mask.
// - an element whose second-mask bit is clear matches any byte.
// - the second pattern counts only while the second-pattern select bit is set.
// - occupancy above the latency ceiling calls for a skip.
// - each correction repeats or skips the adjustment length in bytes.
// - the match length sets how many recent bytes are compared.
// - with retain set the last matched pattern in the buffer is never skipped.
`timescale 1ns/1ns
`default_nettype none
module rcc_rx_clock_correction #(
	parameter int DEPTH     = 32,
	parameter int RD_PERIOD = rcc_pkg::RD_PERIOD_DEF
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        linkClk,
	input  wire logic [rcc_pkg::DATA_W-1:0]  linkData,
	input  wire logic                        bondRequest,
	output logic                             bondGrant,
	output rcc_pkg::rcc_byte_s               rxUser,
	output logic                             corrRepeat,
	output logic                             corrSkip,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [rcc_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	localparam int DW = rcc_pkg::DATA_W;
	localparam int CW = $clog2(RD_PERIOD + 1);

	// configuration registers
	logic [31:0] ctrl_ff;
	logic [31:0] lat_ff;
	logic [31:0] space_ff;
	logic [31:0] seq1_ff;
	logic [31:0] seq2_ff;
	logic [31:0] mask_ff;
	rcc_pkg::rcc_cfg_s cfg;

	assign cfg.ena      = ctrl_ff[rcc_pkg::CTRL_ENA_BIT];
	assign cfg.prio     = ctrl_ff[rcc_pkg::CTRL_PRIO_BIT];
	assign cfg.sel2     = ctrl_ff[rcc_pkg::CTRL_SEL2_BIT];
	assign cfg.keep     = ctrl_ff[rcc_pkg::CTRL_KEEP_BIT];
	assign cfg.adjLen   = ctrl_ff[rcc_pkg::CTRL_ADJ_LSB +: rcc_pkg::LEN_W];
	assign cfg.detLen   = ctrl_ff[rcc_pkg::CTRL_DET_LSB +: rcc_pkg::LEN_W];
	assign cfg.floorLat = lat_ff[rcc_pkg::LAT_FLOOR_LSB +: rcc_pkg::LAT_W];
	assign cfg.ceilLat  = lat_ff[rcc_pkg::LAT_CEIL_LSB +: rcc_pkg::LAT_W];
	assign cfg.spacing  = space_ff[rcc_pkg::SPC_W-1:0];
	assign cfg.seq1     = seq1_ff;
	assign cfg.seq2     = seq2_ff;
	assign cfg.mask1    = mask_ff[rcc_pkg::MASK1_LSB +: rcc_pkg::ELEMS];
	assign cfg.mask2    = mask_ff[rcc_pkg::MASK2_LSB +: rcc_pkg::ELEMS];

	// link side: clock and data both pass two flops before use
	logic [1:0]    lclkSync_ff;
	logic          lclkPrev_ff;
	logic [DW-1:0] ldat1_ff;
	logic [DW-1:0] ldat2_ff;
	logic [DW-1:0] hist_ff [3];
	wire           linkEdge = lclkSync_ff[1] & ~lclkPrev_ff;

	always_ff @(posedge clk)
	begin
		lclkSync_ff <= {lclkSync_ff[0], linkClk};
		lclkPrev_ff <= lclkSync_ff[1];
		ldat1_ff    <= linkData;
		ldat2_ff    <= ldat1_ff;
	end

	always_ff @(posedge clk)
	begin
		if (linkEdge)
		begin
			hist_ff[0] <= ldat2_ff;
			hist_ff[1] <= hist_ff[0];
			hist_ff[2] <= hist_ff[1];
		end
	end

	// newest byte in the low lane, oldest in the high lane
	wire [4*DW-1:0] window = {hist_ff[2], hist_ff[1], hist_ff[0], ldat2_ff};

	function automatic logic seqHit(
		input logic [4*DW-1:0]           seq,
		input logic [3:0]                mask,
		input logic [rcc_pkg::LEN_W-1:0] len,
		input logic [4*DW-1:0]           win
	);
		logic hit;
		int   pos;
		hit = (len != '0) && (len <= 3'h4);
		for (int i = 0; i < 4; i++)
		begin
			pos = int'(len) - 1 - i;
			if (pos >= 0)
			begin
				// cleared mask bit leaves the element as a don't-care
				if (mask[i] && (win[pos*DW +: DW] != seq[i*DW +: DW]))
				begin
					hit = 1'b0;
				end
			end
		end
		return hit;
	endfunction

	wire hit1 = seqHit(cfg.seq1, cfg.mask1, cfg.detLen, window);
	wire hit2 = cfg.sel2 & seqHit(cfg.seq2, cfg.mask2, cfg.detLen, window);
	wire seqMatch = hit1 | hit2;

	// elastic buffer pointers and per-entry pattern-end flags
	logic [PW-1:0]    wp_ff;
	logic [PW-1:0]    rp_ff;
	logic [DEPTH-1:0] flag_ff;
	logic [PW-1:0]    flagCnt;
	wire  [PW-1:0]    occ   = wp_ff - rp_ff;
	wire              full  = occ == PW'(DEPTH);
	wire              empty = occ == '0;
	wire              wrGo  = linkEdge & ~full;

	always_comb
	begin
		flagCnt = '0;
		for (int k = 0; k < DEPTH; k++)
		begin
			if ({1'b0, AW'(AW'(k) - rp_ff[AW-1:0])} < occ && flag_ff[k])
			begin
				flagCnt = flagCnt + PW'(1);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (wrGo)
		begin
			flag_ff[wp_ff[AW-1:0]] <= seqMatch;
		end
	end

	// reader pace
	logic [CW-1:0] rdCnt_ff;
	wire           tick = rdCnt_ff == CW'(RD_PERIOD - 1);

	always_ff @(posedge clk)
	begin
		if (rst || tick)
		begin
			rdCnt_ff <= '0;
		end
		else
		begin
			rdCnt_ff <= rdCnt_ff + CW'(1);
		end
	end

	// correction decision
	logic [rcc_pkg::SPC_W-1:0] spcCnt_ff;
	logic                      haveLast_ff;
	logic                      bondPend_ff;
	wire  [PW-1:0]             adj     = PW'(cfg.adjLen);
	wire  [AW-1:0]             peekIdx = AW'(rp_ff + adj - PW'(1));
	wire  [AW-1:0]             lastIdx = AW'(rp_ff - PW'(1));
	wire spacingOk = spcCnt_ff >= cfg.spacing;
	wire ceilHit   = occ > PW'(cfg.ceilLat);
	wire floorHit  = occ < PW'(cfg.floorLat);
	wire adjOk     = (cfg.adjLen != '0) && (cfg.adjLen <= cfg.detLen);
	wire keepOk    = ~cfg.keep | (flagCnt >= PW'(2));
	// skip only a matched tail, and keep a byte to read after it
	wire skipCond  = cfg.ena & adjOk & spacingOk & ceilHit & keepOk
		& flag_ff[peekIdx] & (occ > adj);
	// repeat only the pattern just delivered
	wire repCond   = cfg.ena & adjOk & spacingOk & floorHit & haveLast_ff
		& flag_ff[lastIdx];
	wire corrWant  = tick & (skipCond | repCond);
	wire bondNow   = bondRequest | bondPend_ff;
	wire collide   = corrWant & bondNow;
	wire corrGo    = corrWant & (~collide | cfg.prio);
	wire bondGo    = bondNow & (~collide | ~cfg.prio);
	wire doSkip    = corrGo & skipCond;
	wire doRep     = corrGo & ~skipCond & repCond;
	wire rdGo      = tick & (doRep | ~empty);
	wire [PW-1:0] rdAddr = doSkip ? rp_ff + adj : (doRep ? rp_ff - adj : rp_ff);

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp_ff       <= '0;
			rp_ff       <= '0;
			haveLast_ff <= 1'b0;
		end
		else
		begin
			if (wrGo)
			begin
				wp_ff <= wp_ff + PW'(1);
			end
			if (rdGo)
			begin
				rp_ff       <= rdAddr + PW'(1);
				haveLast_ff <= 1'b1;
			end
		end
	end

	// saturating count of clk cycles since the last correction
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			spcCnt_ff <= '1;
		end
		else if (corrGo)
		begin
			spcCnt_ff <= '0;
		end
		else if (spcCnt_ff != '1)
		begin
			spcCnt_ff <= spcCnt_ff + rcc_pkg::SPC_W'(1);
		end
	end

	logic [DW-1:0] memData;
	logic          rxValid_ff;
	logic          corrRepeat_ff;
	logic          corrSkip_ff;
	logic          bondGrant_ff;
	logic          ovf_ff;

	rcc_ebuf_mem #(
		.WIDTH (DW),
		.DEPTH (DEPTH)
	) u_mem (
		.clk    (clk),
		.wrEn   (wrGo),
		.wrAddr (wp_ff[AW-1:0]),
		.wrData (ldat2_ff),
		.rdAddr (rdAddr[AW-1:0]),
		.rdData (memData)
	);

	// apb slave: one wait state, writes land when pready is seen
	logic        pready_ff;
	logic        pslverr_ff;
	logic [31:0] prdata_ff;
	wire  apbAcc = psel & penable & ~pready_ff;
	wire  apbWr  = psel & penable & pready_ff & pwrite;
	wire  selCtrl  = paddr == rcc_pkg::OFS_CTRL;
	wire  selLat   = paddr == rcc_pkg::OFS_LAT;
	wire  selSpace = paddr == rcc_pkg::OFS_SPACE;
	wire  selSeq1  = paddr == rcc_pkg::OFS_SEQ1;
	wire  selSeq2  = paddr == rcc_pkg::OFS_SEQ2;
	wire  selMask  = paddr == rcc_pkg::OFS_MASK;
	wire  selStat  = paddr == rcc_pkg::OFS_STAT;
	wire  mapped   = selCtrl | selLat | selSpace | selSeq1 | selSeq2 | selMask | selStat;
	wire  [31:0] statWord = (32'(occ) << rcc_pkg::STAT_OCC_LSB)
		| (32'(flagCnt) << rcc_pkg::STAT_SEQ_LSB)
		| (32'(ovf_ff) << rcc_pkg::STAT_OVF_BIT)
		| (32'(bondPend_ff) << rcc_pkg::STAT_BOND_BIT);
	wire  [31:0] rdMux = selCtrl ? ctrl_ff : selLat ? lat_ff : selSpace ? space_ff
		: selSeq1 ? seq1_ff : selSeq2 ? seq2_ff : selMask ? mask_ff
		: selStat ? statWord : 32'h0000_0000;
	wire  ovfClr = apbWr & selStat & pwdata[rcc_pkg::STAT_OVF_BIT];

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= '0;
		end
		else
		begin
			pready_ff  <= apbAcc;
			pslverr_ff <= apbAcc & ~mapped;
			prdata_ff  <= apbAcc ? rdMux : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_ff  <= rcc_pkg::CTRL_RST;
			lat_ff   <= rcc_pkg::LAT_RST;
			space_ff <= rcc_pkg::SPACE_RST;
			seq1_ff  <= rcc_pkg::SEQ_RST;
			seq2_ff  <= rcc_pkg::SEQ_RST;
			mask_ff  <= rcc_pkg::MASK_RST;
		end
		else if (apbWr)
		begin
			if (selCtrl)
				ctrl_ff <= pwdata & rcc_pkg::CTRL_WMASK;
			if (selLat)
				lat_ff <= pwdata & rcc_pkg::LAT_WMASK;
			if (selSpace)
				space_ff <= pwdata & rcc_pkg::SPACE_WMASK;
			if (selSeq1)
				seq1_ff <= pwdata;
			if (selSeq2)
				seq2_ff <= pwdata;
			if (selMask)
				mask_ff <= pwdata & rcc_pkg::MASK_WMASK;
		end
	end

	// outputs and status; an overflow in the clear cycle stays set
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rxValid_ff    <= 1'b0;
			corrRepeat_ff <= 1'b0;
			corrSkip_ff   <= 1'b0;
			bondGrant_ff  <= 1'b0;
			bondPend_ff   <= 1'b0;
			ovf_ff        <= 1'b0;
		end
		else
		begin
			rxValid_ff    <= rdGo;
			corrRepeat_ff <= doRep;
			corrSkip_ff   <= doSkip;
			bondGrant_ff  <= bondGo;
			bondPend_ff   <= bondNow & ~bondGo;
			ovf_ff        <= (linkEdge & full) | (ovf_ff & ~ovfClr);
		end
	end

	assign rxUser.valid = rxValid_ff;
	assign rxUser.data  = memData;
	assign corrRepeat   = corrRepeat_ff;
	assign corrSkip     = corrSkip_ff;
	assign bondGrant    = bondGrant_ff;
	assign prdata       = prdata_ff;
	assign pready       = pready_ff;
	assign pslverr      = pslverr_ff;
endmodule
`default_nettype wire

// file: bench/rcc_monitor.sv
// port checker of the receive clock correction block
`timescale 1ns/1ns
`default_nettype none
module rcc_monitor (
	input wire logic                       clk,
	input wire logic                       rst,
	input wire logic                       bondRequest,
	input wire logic                       bondGrant,
	input wire rcc_pkg::rcc_byte_s         rxUser,
	input wire logic                       corrRepeat,
	input wire logic                       corrSkip,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [rcc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr
);
	logic       ena_ff;
	logic       prio_ff;
	logic [7:0] spc_ff;
	logic [7:0] gap_ff;
	wire        corr   = corrRepeat || corrSkip;
	wire        wrDone = psel && penable && pready && pwrite && !pslverr;
	// gap starts saturated: first correction is free
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ena_ff  <= 1'b1;
			prio_ff <= 1'b0;
			spc_ff  <= 8'h00;
			gap_ff  <= 8'hff;
		end
		else
		begin
			if (wrDone && paddr == rcc_pkg::OFS_CTRL)
			begin
				ena_ff  <= pwdata[rcc_pkg::CTRL_ENA_BIT];
				prio_ff <= pwdata[rcc_pkg::CTRL_PRIO_BIT];
			end
			if (wrDone && paddr == rcc_pkg::OFS_SPACE)
				spc_ff <= pwdata[7:0];
			gap_ff <= corr ? 8'h00 : (gap_ff == 8'hff ? gap_ff : gap_ff + 8'h01);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_late_grant; !bondGrant ##1 bondGrant; endsequence
	property p_off; !ena_ff && !$past(ena_ff) |-> !corr; endproperty
	property p_space; corr |-> gap_ff >= spc_ff; endproperty
	property p_prio_hi; prio_ff && $past(bondRequest) && corr |-> s_late_grant; endproperty
	property p_prio_lo;
		!prio_ff && !$past(prio_ff) && $past(bondRequest) |-> bondGrant && !corr;
	endproperty
	property p_rep; corrRepeat |-> rxUser.valid; endproperty
	property p_skip; corrSkip |-> rxUser.valid && !corrRepeat; endproperty
	property p_ready; s_access |=> pready; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_off: assert property (p_off) else $error("correction while disabled");
	a_space: assert property (p_space) else $error("corrections too close");
	a_prio_hi: assert property (p_prio_hi) else $error("bond not deferred");
	a_prio_lo: assert property (p_prio_lo) else $error("bond not first");
	a_rep: assert property (p_rep) else $error("repeat without byte");
	a_skip: assert property (p_skip) else $error("skip without byte");
	a_ready: assert property (p_ready) else $error("pready late");
	a_pulse: assert property (p_pulse) else $error("pready too long");
	a_err: assert property (p_err) else $error("bad error answer");
endmodule
bind rcc_rx_clock_correction rcc_monitor i_mon (.clk(clk), .rst(rst),
	.bondRequest(bondRequest), .bondGrant(bondGrant), .rxUser(rxUser),
	.corrRepeat(corrRepeat), .corrSkip(corrSkip), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));
`default_nettype wire

// file: bench/rcc_link_tx.sv
// far transmitter: byte stream with a two-byte pattern every 16 bytes
`timescale 1ns/1ns
`default_nettype none
module rcc_link_tx #(
	parameter logic [7:0] HEAD = 8'hbc,
	parameter logic [7:0] TAIL = 8'h50
) (
	input  wire logic       run,
	output logic            linkClk,
	output logic      [7:0] linkData
);
	function automatic logic [7:0] byteAt(int i);
		if (i % 16 == 14)
			return HEAD;
		if (i % 16 == 15)
			return TAIL;
		return i[7:0];
	endfunction
	initial
	begin : gen
		int n;
		linkClk  = 1'b0;
		linkData = 8'h00;
		#7;
		forever
		begin
			n = 0;
			wait (run === 1'b1);
			while (run === 1'b1)
			begin
				linkData = byteAt(n);
				#62 linkClk = 1'b1;
				#63 linkClk = 1'b0;
				n++;
			end
			// clock stands still, line shows no stale byte
			linkData = ~linkData;
		end
	end
endmodule
`default_nettype wire

// file: bench/rcc_rx_clock_correction_tb.sv
// self-checking bench of the receive clock correction block
`timescale 1ns/1ns
`default_nettype none
module rcc_rx_clock_correction_tb;
	localparam logic [11:0] OFS [7] = '{rcc_pkg::OFS_CTRL, rcc_pkg::OFS_LAT,
		rcc_pkg::OFS_SPACE, rcc_pkg::OFS_SEQ1, rcc_pkg::OFS_SEQ2, rcc_pkg::OFS_MASK,
		rcc_pkg::OFS_STAT};
	localparam logic [31:0] RV [7] = '{rcc_pkg::CTRL_RST, rcc_pkg::LAT_RST,
		rcc_pkg::SPACE_RST, rcc_pkg::SEQ_RST, rcc_pkg::SEQ_RST, rcc_pkg::MASK_RST, 32'h0};
	localparam logic [31:0] WM [7] = '{rcc_pkg::CTRL_WMASK, rcc_pkg::LAT_WMASK,
		rcc_pkg::SPACE_WMASK, 32'hffff_ffff, 32'hffff_ffff, rcc_pkg::MASK_WMASK, 32'h0};
	logic               clk, rst, run, bondOn, bondRequest, bondGrant;
	logic               corrRepeat, corrSkip, linkClk, psel, penable, pwrite, pready;
	logic               pslverr, selB, keepV, err;
	logic [7:0]         linkData;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rd, seqA, seqB;
	logic [3:0]         mskA, mskB;
	rcc_pkg::rcc_byte_s rxUser;
	int                 adjV, detV, idx, nRep, nSkip, miscompares, cmpCount, tick, nSent;
	rcc_rx_clock_correction #(.DEPTH(32), .RD_PERIOD(33)) i_dut (.clk(clk), .rst(rst),
		.linkClk(linkClk), .linkData(linkData), .bondRequest(bondRequest),
		.bondGrant(bondGrant), .rxUser(rxUser), .corrRepeat(corrRepeat),
		.corrSkip(corrSkip), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	rcc_link_tx i_tx (.run(run), .linkClk(linkClk), .linkData(linkData));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic cmp(string n, logic [31:0] e, logic [31:0] g);
		cmpCount++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// only the watchdog ends a wait that never sees pready
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic chk(string nm, logic [11:0] a, logic [31:0] e, logic ee);
		apb(1'b0, a, 32'h0);
		cmp(nm, e, rd);
		cmp({nm, " error"}, ee, err);
	endtask
	function automatic logic hit(logic [31:0] s, logic [3:0] m, int j);
		logic r;
		r = (j >= detV - 1);
		for (int k = 0; k < detV; k++)
			if (m[k] && i_tx.byteAt(j - detV + 1 + k) !== s[8*k+:8])
				r = 1'b0;
		return r;
	endfunction
	function automatic logic endsPat(int j);
		return hit(seqA, mskA, j) || (selB && hit(seqB, mskB, j));
	endfunction
	function automatic logic anyPat(int lo, int hi);
		logic r;
		r = 1'b0;
		for (int j = lo; j <= hi; j++)
			if (endsPat(j))
				r = 1'b1;
		return r;
	endfunction
	// bytes put on the link; a skip with retain set must leave a later pattern end
	always @(posedge linkClk)
		nSent++;
	// bond pulses every 4 cycles drift against the 33-cycle read tick
	always @(posedge clk)
	begin
		tick <= tick + 1;
		bondRequest <= bondOn && (tick % 4 == 0);
	end
	always @(posedge clk)
	begin
		if (rst)
			idx = 0;
		else if (rxUser.valid === 1'b1)
		begin
			if (corrRepeat === 1'b1)
			begin
				nRep++;
				cmp("repeat after pattern", 1, endsPat(idx - 1));
				idx = idx - adjV;
			end
			if (corrSkip === 1'b1)
			begin
				nSkip++;
				cmp("skipped pattern", 1, endsPat(idx + adjV - 1));
				if (keepV === 1'b1)
					cmp("pattern retained", 1, anyPat(idx + adjV, nSent - 1));
				idx = idx + adjV;
			end
			cmp("rx byte", i_tx.byteAt(idx), rxUser.data);
			idx++;
		end
	end
	task automatic phase(string nm, logic [31:0] c, logic [31:0] s1, logic [31:0] s2,
		logic [31:0] m, logic [7:0] sp, int nb, logic bd, int ex);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wr(rcc_pkg::OFS_LAT, 32'h0000_0c08);
		wr(rcc_pkg::OFS_SPACE, {24'h0, sp});
		wr(rcc_pkg::OFS_SEQ1, s1);
		wr(rcc_pkg::OFS_SEQ2, s2);
		wr(rcc_pkg::OFS_MASK, m);
		wr(rcc_pkg::OFS_CTRL, c);
		adjV = c[6:4];
		detV = c[10:8];
		{seqA, seqB, mskA, mskB, selB, keepV} = {s1, s2, m[3:0], m[7:4], c[2], c[3]};
		nRep = 0;
		nSkip = 0;
		nSent = 0;
		bondOn <= bd;
		run <= 1'b1;
		repeat (nb * 32) @(posedge clk);
		run <= 1'b0;
		bondOn <= 1'b0;
		repeat (200) @(posedge clk);
		if (ex == 0)
			cmp({nm, " corrections"}, 0, nRep + nSkip);
		else
			cmp({nm, " repeats"}, 1, nRep > 0);
		if (ex == 2)
			cmp({nm, " skips"}, 1, nSkip > 0);
		$display("test %s ended", nm);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		{rst, run, bondOn, bondRequest, psel, penable, pwrite} = 7'b1000000;
		{paddr, pwdata, tick, miscompares, cmpCount, idx} = '0;
		{adjV, detV, seqA, seqB, mskA, mskB, selB, keepV, nSent} = '0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			chk("reset value", OFS[i], RV[i], 1'b0);
			wr(OFS[i], 32'hffff_ffff);
			chk("writable bits", OFS[i], WM[i], 1'b0);
		end
		chk("unmapped", 12'h01c, 32'h0, 1'b1);
		$display("test registers ended");
		phase("disabled", 32'h0220, 32'h50bc, 32'h0, 32'h03, 8'h00, 60, 1'b1, 0);
		phase("both", 32'h0223, 32'h50bc, 32'h0, 32'h03, 8'hff, 400, 1'b1, 2);
		phase("no match", 32'h0221, 32'h5000, 32'h0, 32'h03, 8'h00, 60, 1'b0, 0);
		phase("dont care", 32'h0221, 32'h5000, 32'h0, 32'h02, 8'h00, 60, 1'b1, 1);
		phase("second off", 32'h0221, 32'h5000, 32'h50bc, 32'h33, 8'h00, 60, 1'b0, 0);
		phase("second on", 32'h0225, 32'h5000, 32'h5000, 32'h23, 8'h00, 60, 1'b0, 1);
		phase("retain", 32'h0319, 32'h50bc00, 32'h0, 32'h06, 8'h00, 400, 1'b0, 2);
		end_of_test;
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		miscompares++;
		end_of_test;
	end
endmodule
`default_nettype wire
